// >>> src/event_timer.sv
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.svh"

module event_timer #(
  parameter int unsigned PSC_W = `PSC_STAGES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave, byte address
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Counter pin, asynchronous
  input wire logic counter_pin,
  // Events and shared divider pin
  output logic overflow_irq,
  output logic wake_pulse,
  output logic freq_divider_output
);

  // Register storage
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] preload_reg;
  logic [7:0] preload_next;
  logic [1:0] mode_reg;
  logic active_edge_select;
  logic edge_next;
  logic count_enable_bit;
  logic enable_next;
  logic [2:0] prescale_reg;
  logic [2:0] prescale_next;
  logic overflow_request_flag;
  logic flag_next;
  logic overflow_int_enable;
  logic inten_next;
  logic pin_latch_reg;
  logic pin_sel_reg;
  logic toggle_reg;
  logic toggle_next;
  logic [PSC_W-1:0] psc_cnt_reg;
  timer_pkg::pw_state_t pw_reg;
  timer_pkg::pw_state_t pw_next;

  // Bus handshake and registered event outputs
  logic waitrequest_reg;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;
  logic irq_reg;
  logic wake_reg;
  logic pfd_reg;

  // Pin synchroniser
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic pin_prev_reg;

  function automatic logic psc_tick(input logic [PSC_W-1:0] cnt,
                                    input logic [2:0] sel);
    logic [PSC_W-1:0] mask;
    mask = PSC_W'((8'h01 << sel) - 8'h01);
    psc_tick = (cnt & mask) == mask;
  endfunction : psc_tick

  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] idx);
    hit = addr == 8'(idx << 2);
  endfunction : hit

  // Address decode
  wire req = read | write;
  wire take = req & waitrequest_reg;
  wire done = req & ~waitrequest_reg;
  wire cnt_hit = hit(address, `CNT_IDX);
  wire ctrl_hit = hit(address, `CTRL_IDX);
  wire interrupt_control_hit = hit(address, `INTERRUPT_CONTROL_IDX);
  wire div_hit = hit(address, `DIVPIN_IDX);
  wire wr_ok = done & write & byteenable[0];
  wire wr_cnt = wr_ok & cnt_hit;
  wire wr_ctrl = wr_ok & ctrl_hit;
  wire wr_interrupt_control = wr_ok & interrupt_control_hit;
  wire wr_div = wr_ok & div_hit;
  wire [7:0] wbyte = writedata[7:0];

  // Mode and edge decode
  wire is_event = mode_reg == timer_pkg::MODE_EVENT;
  wire is_timer = mode_reg == timer_pkg::MODE_TIMER;
  wire is_pulse = mode_reg == timer_pkg::MODE_PULSE;
  wire rise = pin_sync_reg & ~pin_prev_reg;
  wire fall = ~pin_sync_reg & pin_prev_reg;
  // A set edge bit selects falling edges in event mode
  wire event_edge = active_edge_select ? fall : rise;
  // In pulse mode a set edge bit measures high time
  wire start_edge = active_edge_select ? rise : fall;
  wire stop_edge = active_edge_select ? fall : rise;
  wire f_int = psc_tick(psc_cnt_reg, prescale_reg);

  // The count clock is held off for the whole read so the value is stable;
  // ticks arriving then are lost, which software has to tolerate.
  wire read_block = read & cnt_hit;
  wire measuring = is_pulse & (pw_reg == timer_pkg::PW_MEASURE);
  wire raw_tick = (is_event & event_edge)
                | (is_timer & f_int)
                | (measuring & f_int);
  wire tick = count_enable_bit & raw_tick & ~read_block;
  wire overflow = tick & (count_reg == 8'hff);
  wire pw_stop = count_enable_bit & measuring & stop_edge;

  // Counter and preload
  always_comb
  begin
    preload_next = preload_reg;
    count_next = count_reg;
    if (wr_cnt)
    begin
      preload_next = wbyte;
    end
    if (overflow)
    begin
      count_next = wr_cnt ? wbyte : preload_reg;
    end
    else if (tick)
    begin
      count_next = count_reg + 8'h01;
    end
    if (wr_cnt && !count_enable_bit)
    begin
      count_next = wbyte;
    end
  end

  // Control fields
  always_comb
  begin
    enable_next = count_enable_bit;
    edge_next = active_edge_select;
    prescale_next = prescale_reg;
    // Only pulse mode ever clears the enable by itself
    if (pw_stop)
    begin
      enable_next = 1'b0;
    end
    if (wr_ctrl)
    begin
      enable_next = wbyte[`ENABLE_BIT];
      edge_next = wbyte[`EDGE_BIT];
      prescale_next = wbyte[`PSC_LSB +: 3];
    end
  end

  // Pulse measurement sequencer
  always_comb
  begin
    pw_next = pw_reg;
    case (pw_reg)
      timer_pkg::PW_WAIT:
      begin
        if (is_pulse && count_enable_bit && start_edge)
        begin
          pw_next = timer_pkg::PW_MEASURE;
        end
      end
      timer_pkg::PW_MEASURE:
      begin
        if (!is_pulse || !count_enable_bit || stop_edge)
        begin
          pw_next = timer_pkg::PW_WAIT;
        end
      end
      default:
      begin
        pw_next = timer_pkg::PW_WAIT;
      end
    endcase
  end

  // Flag: a hardware set beats a software clear in the same cycle
  always_comb
  begin
    flag_next = overflow_request_flag;
    inten_next = overflow_int_enable;
    if (wr_interrupt_control)
    begin
      flag_next = wbyte[`FLAG_BIT];
      inten_next = wbyte[`INTEN_BIT];
    end
    if (overflow)
    begin
      flag_next = 1'b1;
    end
  end

  // Divider flip-flop halves the overflow rate
  always_comb
  begin
    toggle_next = toggle_reg;
    if (overflow)
    begin
      toggle_next = ~toggle_reg;
    end
  end

  // Read mux
  always_comb
  begin
    readdata_next = 32'h0000_0000;
    if (cnt_hit)
    begin
      readdata_next[7:0] = count_reg;
    end
    else if (ctrl_hit)
    begin
      readdata_next[7:0] = {mode_reg, 1'b0, count_enable_bit,
                            active_edge_select, prescale_reg};
    end
    else if (interrupt_control_hit)
    begin
      readdata_next[`FLAG_BIT] = overflow_request_flag;
      readdata_next[`INTEN_BIT] = overflow_int_enable;
    end
    else if (div_hit)
    begin
      readdata_next[`LATCH_BIT] = pin_latch_reg;
      readdata_next[`DIVSEL_BIT] = pin_sel_reg;
    end
  end

  // Synchroniser: the first stage feeds no logic; edges compare the second and third stages
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= counter_pin;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // Prescaler runs free so the tick phase is independent of writes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      psc_cnt_reg <= '0;
    end
    else
    begin
      psc_cnt_reg <= psc_cnt_reg + 1'b1;
    end
  end

  // Counting state
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count_reg <= 8'h00;
      preload_reg <= 8'h00;
      toggle_reg <= 1'b0;
      pw_reg <= timer_pkg::PW_WAIT;
    end
    else
    begin
      count_reg <= count_next;
      preload_reg <= preload_next;
      toggle_reg <= toggle_next;
      pw_reg <= pw_next;
    end
  end

  // Control and interrupt registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mode_reg <= 2'(`CTRL_RESET >> `MODE_LSB);
      count_enable_bit <= 1'((`CTRL_RESET >> `ENABLE_BIT) & 8'h01);
      active_edge_select <= 1'((`CTRL_RESET >> `EDGE_BIT) & 8'h01);
      prescale_reg <= 3'(`CTRL_RESET);
      overflow_request_flag <= 1'((`INTERRUPT_CONTROL_RESET >> `FLAG_BIT) & 8'h01);
      overflow_int_enable <= 1'((`INTERRUPT_CONTROL_RESET >> `INTEN_BIT) & 8'h01);
    end
    else
    begin
      if (wr_ctrl)
      begin
        mode_reg <= wbyte[`MODE_LSB +: 2];
      end
      count_enable_bit <= enable_next;
      active_edge_select <= edge_next;
      prescale_reg <= prescale_next;
      overflow_request_flag <= flag_next;
      overflow_int_enable <= inten_next;
    end
  end

  // Shared pin control
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_latch_reg <= 1'((`DIVPIN_RESET >> `LATCH_BIT) & 8'h01);
      pin_sel_reg <= 1'((`DIVPIN_RESET >> `DIVSEL_BIT) & 8'h01);
    end
    else if (wr_div)
    begin
      pin_latch_reg <= wbyte[`LATCH_BIT];
      pin_sel_reg <= wbyte[`DIVSEL_BIT];
    end
  end

  // Bus answer: one wait cycle, then waitrequest low for one cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      waitrequest_reg <= 1'b1;
      readdata_reg <= 32'h0000_0000;
    end
    else
    begin
      waitrequest_reg <= ~take;
      if (take && read)
      begin
        readdata_reg <= readdata_next;
      end
    end
  end

  // Event outputs
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
      pfd_reg <= 1'b0;
    end
    else
    begin
      // Request gated by the enable, whatever the mode
      irq_reg <= flag_next & inten_next;
      wake_reg <= overflow;
      // Latch low forces the pin low; unselected leaves it low too
      pfd_reg <= toggle_next & pin_sel_reg & pin_latch_reg;
    end
  end

  assign readdata = readdata_reg;
  assign waitrequest = waitrequest_reg;
  assign overflow_irq = irq_reg;
  assign wake_pulse = wake_reg;
  assign freq_divider_output = pfd_reg;

endmodule : event_timer
`default_nettype wire

// >>> src/timer_map.svh
// Functional notes
// - Eight-bit up-counter clocked by the counter pin or the prescaled clock.
// - Event mode counts pin edges; timer and pulse modes count prescaled ticks.
// - One address: writes go to preload, reads return the live count.
// - Mode bits 7:6: 01 event, 10 timer, 11 pulse width, 00 unused.
// - Event/timer count up to ff, reload from preload, set flag bit 5.
// - Pulse mode: start on chosen edge, stop on return, clear enable.
// - After one measurement the result holds until software re-enables.
// - Pulse mode reacts to pin edges, not to the pin level.
// - Overflow in pulse mode reloads and raises the request as elsewhere.
// - Counting only with enable bit 4; event/timer never clear it.
// - Counter overflow is a wake-up source.
// - With the interrupt enable bit low the overflow is never serviced.
// - Bits 2:0 divide the system clock by two to that power.
// - Event mode: bit 3 one counts falling edges, zero rising edges.
// - Pulse mode: bit 3 one measures high pulses, zero low pulses.
// - Control bit 5 is unimplemented and reads zero.
// - Preload write also loads the counter only while counting is off.
// - A counter read blocks the count clock while it is in progress.
// - Divider output frequency is f_int / (2 * (256 - preload)).
// - Divider toggles per overflow; drives pin if selected and latch is one.
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH
`define CNT_IDX 8'h0d
`define CTRL_IDX 8'h0e
`define INTERRUPT_CONTROL_IDX 8'h0b
`define DIVPIN_IDX 8'h12
`define CTRL_RESET 8'h08
`define INTERRUPT_CONTROL_RESET 8'h00
`define DIVPIN_RESET 8'h00
`define MODE_LSB 6
`define ENABLE_BIT 4
`define UNUSED_BIT 5
`define EDGE_BIT 3
`define PSC_LSB 0
`define FLAG_BIT 5
`define INTEN_BIT 2
`define LATCH_BIT 0
`define DIVSEL_BIT 1
`define PSC_STAGES 7
`endif

// >>> src/timer_pkg.sv
package timer_pkg;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_EVENT = 2'h1,
    MODE_TIMER = 2'h2,
    MODE_PULSE = 2'h3
  } mode_t;

  typedef enum logic [1:0] {
    PW_WAIT = 2'h1,
    PW_MEASURE = 2'h2
  } pw_state_t;

endpackage : timer_pkg

// >>> test/event_timer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module event_timer_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Events
  input wire logic overflow_irq,
  input wire logic wake_pulse,
  input wire logic freq_divider_output
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire wdone = write && !waitrequest;
  wire stop_wr = wdone && address == 8'h38 && !writedata[4];
  sequence req_seen;
    (read || write) && waitrequest;
  endsequence
  sequence one_beat;
    !waitrequest ##1 waitrequest;
  endsequence
  AST_ANSWER: assert property (req_seen |=> one_beat)
    else $error("bus answer late");
  AST_IDLE: assert property (!(read || write) && waitrequest |=> waitrequest)
    else $error("answer without request");
  AST_CTRL_BIT5: assert property (read && !waitrequest && address == 8'h38
    |-> readdata[5] == 1'b0 && readdata[31:8] == 24'h0)
    else $error("control bit 5 not zero");
  AST_RDATA_HOLD: assert property ($changed(readdata) |-> read && !waitrequest)
    else $error("read data moved");
  AST_FLAG_HOLD: assert property ($fell(overflow_irq)
    |-> $past(wdone, 1) || $past(wdone, 2))
    else $error("request dropped alone");
  AST_IRQ_CAUSE: assert property ($rose(overflow_irq)
    |-> wake_pulse || $past(wake_pulse) || $past(wdone, 1) || $past(wdone, 2))
    else $error("request without cause");
  AST_DIV_CAUSE: assert property ($changed(freq_divider_output)
    |-> wake_pulse || $past(wake_pulse) || $past(wdone, 1) || $past(wdone, 2))
    else $error("divider moved without overflow");
  AST_STOPPED: assert property (stop_wr |=> ##2 (!wake_pulse) [*8])
    else $error("overflow while stopped");
endmodule : event_timer_properties
`default_nettype wire

// >>> test/event_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(s, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("Error %s expected %0h seen %0h", s, e, g); end end
module event_timer_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest, overflow_irq, wake_pulse, freq_divider_output, dv;
  wire counter_pin;
  logic [7:0] q;
  int n_mismatch = 0, num_checks = 0, cycles = 0, k, t, e, p, w, x;
  always #2.5 clk = ~clk;
  event_timer event_timer_i (.clk(clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .counter_pin(counter_pin), .overflow_irq(overflow_irq),
    .wake_pulse(wake_pulse), .freq_divider_output(freq_divider_output));
  pin_source pin_source_i (.clk(clk), .counter_pin(counter_pin));
  // Reference count from the mode, edge and enable rules; the bus task
  // keeps its copy of the registers
  int m_count = 0, m_preload = 0;
  logic [7:0] m_ctrl = 8'h08;
  logic m_pin = 1'b0;
  always @(posedge clk)
  begin
    if (m_ctrl[7:6] == 2'b01 && m_ctrl[4] && counter_pin !== m_pin
        && counter_pin === ~m_ctrl[3])
    begin
      m_count = (m_count == 255) ? m_preload : m_count + 1;
    end
    m_pin = counter_pin;
  end
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {24'h0, d};
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata[7:0];
    if (wr && byteenable[0] && a == 8'h34)
    begin
      m_preload = d;
      m_count = m_ctrl[4] ? m_count : int'(d);
    end
    if (wr && byteenable[0] && a == 8'h38)
    begin
      m_ctrl = d;
    end
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // Ceiling is over twenty times the expected run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial
  begin
    void'($urandom(32'h124777f5));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, 8'h38, 0); `CHK("ctrl reset", 8'h08, q)
    bus(0, 8'h34, 0); `CHK("count reset", 0, q)
    bus(0, 8'h40, 0); `CHK("unmapped", 0, q)
    bus(1, 8'h38, 8'hff);
    bus(0, 8'h38, 0); `CHK("ctrl rb", 8'hdf, q)
    bus(1, 8'h38, 0);
    byteenable <= 4'he;
    bus(1, 8'h38, 8'hff);
    byteenable <= 4'hf;
    bus(0, 8'h38, 0); `CHK("lane off", 8'h00, q)
    done("registers");
    for (e = 0; e < 2; e++)
    begin
      k = 1 + $urandom % 6;
      bus(1, 8'h34, 0);
      bus(1, 8'h38, 8'(8'h50 | (e << 3)));
      repeat (k) pin_source_i.pulse(1'b1, 3);
      pin_source_i.set_level(1'b1);
      repeat (6) @(posedge clk);
      bus(0, 8'h34, 0); `CHK("events", e ? k : k + 1, q)
      `CHK("model count", m_count, q)
      bus(0, 8'h38, 0); `CHK("enable", 8'(8'h50 | (e << 3)), q)
      bus(1, 8'h34, 8'h33);
      bus(0, 8'h34, 0); `CHK("preload only", m_count, q)
      bus(1, 8'h38, 0);
      pin_source_i.set_level(1'b0);
    end
    done("event");
    for (e = 0; e < 2; e++)
    begin
      // The high pulse starts near the top so that it must overflow
      k = 4 + $urandom % 40 + 16 * e;
      pin_source_i.set_level(e == 0);
      repeat (4) @(posedge clk);
      bus(1, 8'h34, 8'(e ? 8'hf0 : 8'h00));
      bus(1, 8'h38, 8'(8'hd0 | (e << 3)));
      pin_source_i.pulse(e == 1, k);
      repeat (6) @(posedge clk);
      bus(0, 8'h38, 0); `CHK("auto stop", 8'(8'hc0 | (e << 3)), q)
      m_ctrl[4] = 1'b0;
      bus(0, 8'h34, 0);
      `CHK("width", 8'(e ? 8'hf0 + k % 16 : k), q)
      x = q;
      pin_source_i.pulse(e == 1, 5);
      repeat (6) @(posedge clk);
      bus(0, 8'h34, 0); `CHK("held", x, q)
    end
    done("pulse");
    bus(1, 8'h48, 8'h03);
    for (p = 0; p < 4; p++)
    begin
      bus(1, 8'h38, 0);
      bus(1, 8'h34, 8'hfc);
      bus(1, 8'h2c, 8'h04);
      bus(1, 8'h38, 8'(8'h90 | p));
      t = 0;
      w = 0;
      dv = freq_divider_output;
      repeat (256)
      begin
        @(posedge clk);
        t += (freq_divider_output !== dv);
        w += (wake_pulse === 1'b1);
        dv = freq_divider_output;
      end
      x = 256 / (4 << p);
      `CHK("toggles", 1, t >= x - 1 && t <= x + 1)
      `CHK("wake", 1, w >= t - 1 && w <= t + 1)
      bus(0, 8'h2c, 0); `CHK("flag", 8'h24, q)
      `CHK("irq", 1'b1, overflow_irq)
    end
    bus(1, 8'h38, 0);
    bus(1, 8'h2c, 8'h20);
    repeat (3) @(posedge clk);
    `CHK("masked", 1'b0, overflow_irq)
    bus(1, 8'h48, 8'h02);
    repeat (3) @(posedge clk);
    `CHK("latch off", 1'b0, freq_divider_output)
    bus(1, 8'h34, 8'h00);
    bus(1, 8'h38, 8'h90);
    bus(0, 8'h34, 0);
    x = q;
    // Two reads one idle cycle apart: only that idle cycle may count
    bus(0, 8'h34, 0);
    `CHK("read block", 8'h01, 8'(q - x[7:0]))
    bus(1, 8'h38, 0);
    done("timer");
    tally_and_finish();
  end
endmodule : event_timer_test
bind event_timer event_timer_properties event_timer_properties_i (
  .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .overflow_irq(overflow_irq), .wake_pulse(wake_pulse),
  .freq_divider_output(freq_divider_output));
`default_nettype wire

// >>> test/pin_source.sv
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  // Clock
  input wire logic clk,
  // Counter pin
  output logic counter_pin
);
  initial counter_pin = 1'b0;
  task automatic set_level(input logic lvl);
    @(posedge clk);
    counter_pin <= lvl;
  endtask : set_level
  // A pulse is two edges, never a bare level
  task automatic pulse(input logic lvl, input int n);
    set_level(lvl);
    repeat (n) @(posedge clk);
    counter_pin <= !lvl;
  endtask : pulse
endmodule : pin_source
`default_nettype wire
